/* hsfs_pkg.sv */
// Package of constants for the hot swap fault supervisor.
// Assumes a 200 MHz supervisor clock; timer counts derive from it.
//
// Behaviour
// (RULE1) Steady-state capacitor pin below low threshold flags a short.
// (RULE2) Steady-state cap short sets hard fault; gate stays on.
// (RULE3) Hard fault clears only on regulator lockout.
// (RULE4) Cap short detection is off while overcurrent is reported.
// (RULE5) After overcurrent ends, detection stays off until re-arm delay.
// (RULE6) Overcurrent with cap low runs sense timer; timeout trips breaker.
// (RULE7) Cap not above high threshold at re-arm expiry sets hard fault.
// (RULE8) With gate on, open output feedback trips the breaker.
// (RULE9) Open return feedback trips the breaker.
// (RULE10) Open-pin breaker clears on enable falling or regulator lockout.
// (RULE11) Undervoltage or overvoltage disables gate and raises discharge.
// (RULE12) Supply recovery re-enables gate and lowers discharge.
// (RULE13) Gate on needs regulator up, power-on timer done, enable rising.
// (RULE14) Power good and monitor follow output and gate-source good.
// (RULE15) Turning the switch off drops power good and the current monitor.
// (RULE16) Inputs are synchronised; latches reset only on lockout. The breaker and current fault also clear on enable falling.

package hsfs_pkg;

   localparam int unsigned CLK_MHZ             = 200;
   // Re-arm delay after overcurrent, in microseconds.
   localparam int unsigned REARM_DELAY_US      = 100;
   localparam int unsigned REARM_DELAY_CYC     = REARM_DELAY_US * CLK_MHZ;
   // Overcurrent sense delay with capacitor low, in microseconds.
   localparam int unsigned OC_SENSE_DELAY_US   = 10;
   localparam int unsigned OC_SENSE_DELAY_CYC  = OC_SENSE_DELAY_US * CLK_MHZ;
   // Power-on timer after regulator rise, in microseconds.
   localparam int unsigned POR_DELAY_US        = 1000;
   localparam int unsigned POR_DELAY_CYC       = POR_DELAY_US * CLK_MHZ;
   localparam int unsigned SYNC_WIDTH          = 10;
   localparam logic        RST_GATE            = 1'b0;

   typedef enum logic [1:0] {
      HSFS_IDLE,
      HSFS_ON,
      HSFS_TRIP
   } hsfs_state_e;

endpackage : hsfs_pkg

/* hsfs_sync.sv */
// Two-flop synchroniser bank for the comparator and enable inputs.
// Assumes each input is a slow level from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none

module hsfs_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Data
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;

   // The first stage feeds only the second stage.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in; // RULE16
         sync_out <= meta_q;
      end
   end
endmodule : hsfs_sync

`default_nettype wire

/* hsfs_top.sv */
// Fault supervisor of a single-channel hot swap controller.
// Assumes comparator results arrive as asynchronous digital levels.
`timescale 1ns/100ps
`default_nettype none

module hsfs_top #(
   parameter int unsigned REARM_CYC    = hsfs_pkg::REARM_DELAY_CYC,
   parameter int unsigned OC_SENSE_CYC = hsfs_pkg::OC_SENSE_DELAY_CYC,
   parameter int unsigned POR_CYC      = hsfs_pkg::POR_DELAY_CYC
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_b,
   // Service processor
   input  wire logic enable_in,
   // Comparators
   input  wire logic regulator_above_rise_in,
   input  wire logic regulator_below_drop_in,
   input  wire logic cap_below_low_in,
   input  wire logic cap_above_high_in,
   input  wire logic primary_oc_in,
   input  wire logic output_feedback_open_in,
   input  wire logic return_feedback_open_in,
   input  wire logic undervoltage_low_in,
   input  wire logic overvoltage_high_in,
   input  wire logic output_good_in,
   input  wire logic gate_source_good_in,
   // Outputs
   output logic      gate_enable_out,
   output logic      fault_pulldown_out,
   output logic      discharge_out,
   output logic      power_good_out,
   output logic      current_monitor_out,
   output logic      current_fault_out,
   output logic      hard_fault_latched_out
);
   import hsfs_pkg::*;

   initial begin
      if (REARM_CYC < 1 || OC_SENSE_CYC < 1 || POR_CYC < 1 ||
          REARM_CYC >= 2**24 || OC_SENSE_CYC >= 2**24 || POR_CYC >= 2**24)
         $error("hsfs_top: timer counts out of range");
   end

   logic [SYNC_WIDTH-1:0] raw;
   logic [SYNC_WIDTH-1:0] syn;
   logic en_s;
   logic reg_up_s;
   logic cap_low_s;
   logic cap_high_s;
   logic oc_s;
   logic ofb_open_s;
   logic rfb_open_s;
   logic uv_s;
   logic ov_s;
   logic pg_cond_s;
   logic reg_down_q;
   logic reg_down_m_q;

   assign raw = {enable_in, regulator_above_rise_in, cap_below_low_in,
                 cap_above_high_in, primary_oc_in, output_feedback_open_in,
                 return_feedback_open_in, undervoltage_low_in,
                 overvoltage_high_in, output_good_in & gate_source_good_in};

   hsfs_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
      .clk_sys  (clk_sys),
      .rst_b    (rst_b),
      .async_in (raw),
      .sync_out (syn)
   );

   assign {en_s, reg_up_s, cap_low_s, cap_high_s, oc_s, ofb_open_s,
           rfb_open_s, uv_s, ov_s, pg_cond_s} = syn;

   // Lockout is synchronised separately so it can also act as a local reset.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         reg_down_m_q <= 1'b1;
         reg_down_q   <= 1'b1;
      end else begin
         reg_down_m_q <= regulator_below_drop_in; // RULE16
         reg_down_q   <= reg_down_m_q;
      end
   end

   // Power-on timer after the regulator rises.
   logic [23:0] por_cnt_q;
   logic        por_done_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         por_cnt_q  <= '0;
         por_done_q <= 1'b0;
      end else if (reg_down_q || !reg_up_s) begin
         por_cnt_q  <= '0;
         por_done_q <= 1'b0;
      end else if (!por_done_q) begin
         por_cnt_q  <= por_cnt_q + 24'h00_0001;
         por_done_q <= (por_cnt_q == 24'(POR_CYC - 1));
      end
   end

   logic en_prev_q;
   logic en_rise;
   logic en_fall;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) en_prev_q <= 1'b0;
      else        en_prev_q <= en_s;
   end
   assign en_rise = en_s & ~en_prev_q;
   assign en_fall = ~en_s & en_prev_q;

   // Breaker from open sense pins or the overcurrent sense timeout.
   logic        brk_q;
   logic        oc_trip;
   logic        open_trip;
   logic [23:0] sense_cnt_q;
   logic        armed_q;
   logic        supply_bad;
   logic        on_q;

   assign supply_bad = uv_s | ov_s; // RULE11
   assign open_trip  = (on_q & ofb_open_s) | rfb_open_s; // RULE8 RULE9

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sense_cnt_q <= '0;
      end else if (oc_s && cap_low_s && !brk_q) begin
         sense_cnt_q <= sense_cnt_q + 24'h00_0001; // RULE6
      end else begin
         sense_cnt_q <= '0;
      end
   end
   assign oc_trip = oc_s && cap_low_s &&
                    (sense_cnt_q == 24'(OC_SENSE_CYC - 1)); // RULE6

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         brk_q             <= 1'b0;
         current_fault_out <= 1'b0;
      end else if (reg_down_q) begin
         brk_q             <= 1'b0; // RULE10
         current_fault_out <= 1'b0;
      end else if (oc_trip) begin
         brk_q             <= 1'b1; // RULE6
         current_fault_out <= 1'b1;
      end else if (open_trip) begin
         brk_q             <= 1'b1; // RULE8 RULE9
      end else if (en_fall) begin
         brk_q             <= 1'b0; // RULE10
         current_fault_out <= 1'b0;
      end
   end

   // Gate control: on needs regulator, power-on timer and enable rising.
   hsfs_state_e state_q;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= HSFS_IDLE;
      end else if (reg_down_q || !reg_up_s) begin
         state_q <= HSFS_IDLE;
      end else begin
         case (state_q)
            HSFS_IDLE:
               if (en_rise && por_done_q && !brk_q)
                  state_q <= HSFS_ON; // RULE13
            HSFS_ON:
               if (!en_s) state_q <= HSFS_IDLE;
               else if (oc_trip || open_trip) state_q <= HSFS_TRIP;
            HSFS_TRIP:
               if (!brk_q) state_q <= HSFS_IDLE; // RULE10
            default: state_q <= HSFS_IDLE;
         endcase
      end
   end
   assign on_q = (state_q == HSFS_ON);

   // Supply faults override the gate without changing state, so recovery
   // from them is automatic.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         gate_enable_out    <= RST_GATE;
         fault_pulldown_out <= 1'b0;
         discharge_out      <= 1'b0;
      end else begin
         gate_enable_out    <= on_q & ~supply_bad & ~oc_trip &
                               ~open_trip; // RULE12
         fault_pulldown_out <= (state_q == HSFS_TRIP) | oc_trip |
                               (on_q & open_trip) | supply_bad; // RULE11
         discharge_out      <= ~(on_q & ~supply_bad & ~oc_trip &
                               ~open_trip); // RULE12
      end
   end

   // Power good and current monitor follow the switch being on.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         power_good_out      <= 1'b0;
         current_monitor_out <= 1'b0;
      end else begin
         power_good_out      <= gate_enable_out & pg_cond_s; // RULE14 RULE15
         current_monitor_out <= gate_enable_out & pg_cond_s; // RULE14 RULE15
      end
   end

   // Capacitor short detection with the overcurrent re-arm delay.
   logic [23:0] rearm_cnt_q;
   logic        rearm_run_q;
   logic        rearm_expire;
   assign rearm_expire = rearm_run_q && !oc_s &&
                         (rearm_cnt_q == 24'(REARM_CYC - 1));
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         armed_q     <= 1'b1;
         rearm_run_q <= 1'b0;
         rearm_cnt_q <= '0;
      end else if (oc_s) begin
         armed_q     <= 1'b0; // RULE4
         rearm_run_q <= 1'b1;
         rearm_cnt_q <= '0;
      end else if (rearm_run_q) begin
         rearm_cnt_q <= rearm_cnt_q + 24'h00_0001; // RULE5
         if (rearm_expire) begin
            rearm_run_q <= 1'b0;
            armed_q     <= 1'b1;
         end
      end
   end

   // A slow capacitor with a long power-on timer is a real short, so a stale
   // low during the power-on window is ignored until steady state.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hard_fault_latched_out <= 1'b0;
      end else if (reg_down_q) begin
         hard_fault_latched_out <= 1'b0; // RULE3 RULE16
      end else if ((armed_q && !oc_s && por_done_q && cap_low_s) ||
                   (rearm_expire && !cap_high_s)) begin
         hard_fault_latched_out <= 1'b1; // RULE1 RULE2 RULE7
      end
   end

   a_hard_fault_hold: assert property (@(posedge clk_sys) // RULE3
      disable iff (!rst_b)
      hard_fault_latched_out && !reg_down_q |=> hard_fault_latched_out)
      else $error("hard fault dropped without lockout");
   a_oc_masks_short: assert property (@(posedge clk_sys) // RULE4
      disable iff (!rst_b) oc_s && !rearm_expire |=> !armed_q)
      else $error("short detection armed during overcurrent");
   a_rearm_wait: assert property (@(posedge clk_sys) // RULE5
      disable iff (!rst_b) $fell(oc_s) |=> !armed_q [*2])
      else $error("short detection re-armed early");
   a_steady_short: assert property (@(posedge clk_sys) // RULE1
      disable iff (!rst_b) armed_q && !oc_s && por_done_q && cap_low_s
      && !reg_down_q |=> hard_fault_latched_out)
      else $error("steady short not flagged");
   a_short_keeps_gate: assert property (@(posedge clk_sys) // RULE2
      disable iff (!rst_b) $rose(hard_fault_latched_out) && $past(on_q)
      && !$past(supply_bad) && !$past(oc_trip) && !$past(open_trip)
      |-> gate_enable_out)
      else $error("cap short turned gate off");
   a_oc_trip_out: assert property (@(posedge clk_sys) // RULE6
      disable iff (!rst_b) oc_trip && !reg_down_q |=> current_fault_out
      && !gate_enable_out && discharge_out && fault_pulldown_out)
      else $error("overcurrent trip outputs wrong");
   a_supply_off: assert property (@(posedge clk_sys) // RULE11
      disable iff (!rst_b) supply_bad |=> !gate_enable_out && discharge_out)
      else $error("supply fault left gate on");
   a_open_trip: assert property (@(posedge clk_sys) // RULE9
      disable iff (!rst_b) rfb_open_s && !reg_down_q |=> brk_q
      ##1 !gate_enable_out)
      else $error("open return feedback not tripped");
   a_pg_gate: assert property (@(posedge clk_sys) // RULE14
      disable iff (!rst_b)
      power_good_out |-> $past(gate_enable_out) && $past(pg_cond_s))
      else $error("power good without gate");
   a_gate_cause: assert property (@(posedge clk_sys) // RULE13
      disable iff (!rst_b)
      $rose(on_q) |-> $past(en_rise) && $past(por_done_q))
      else $error("gate on without enable edge");

   c_steady_short: cover property (@(posedge clk_sys) disable iff (!rst_b)
      on_q ##1 $rose(hard_fault_latched_out));
   c_oc_trip: cover property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(current_fault_out));
   c_open_recover: cover property (@(posedge clk_sys) disable iff (!rst_b)
      state_q == HSFS_TRIP ##1 state_q == HSFS_IDLE);
   c_power_good: cover property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(power_good_out));
endmodule : hsfs_top

`default_nettype wire

/* hsfs_fet_model.sv */
// Model of the external switch as seen by the output and gate comparators.
// Assumes the gate enable is a registered level on the supervisor clock.
`timescale 1ns/100ps
`default_nettype none

module hsfs_fet_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rst_b,
   // Switch control and response lag
   input  wire logic       gate_enable_out,
   input  wire logic [3:0] lag,
   // Comparator results
   output logic            output_good_in,
   output logic            gate_source_good_in
);
   logic [3:0] ramp_q;

   // The gate charges over lag + 1 cycles but collapses at once, as a real
   // pull-down does.
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ramp_q <= 4'h0;
      end else if (!gate_enable_out) begin
         ramp_q <= 4'h0;
      end else if (ramp_q != 4'hf) begin
         ramp_q <= ramp_q + 4'h1;
      end
   end

   assign gate_source_good_in = gate_enable_out &&
                                (ramp_q > lag);
   assign output_good_in      = gate_source_good_in;
endmodule : hsfs_fet_model
`default_nettype wire

/* tb_hsfs_top.sv */
// Self-checking bench for the hot swap fault supervisor.
// Assumes the switch model drives the power good comparators.
`timescale 1ns/100ps
`default_nettype none

module tb_hsfs_top;
   localparam int POR = 16;
   localparam int OCS = 4;
   localparam int RRM = 8;
   localparam logic [6:0] M_ALL = 7'h7f;
   localparam logic [6:0] M_NIF = 7'h7d;
   localparam logic [6:0] M_OFF = 7'h5d;
   localparam logic [6:0] M_HF  = 7'h01;

   logic clk_sys = 1'b0, rst_b = 1'b0, enable_in = 1'b0;
   logic reg_rise = 1'b0, reg_drop = 1'b1, cap_low = 1'b0, cap_high = 1'b1;
   logic oc = 1'b0, ofb = 1'b0, rfb = 1'b0, uv = 1'b0, ov = 1'b0;
   logic out_good, gs_good, g, p, d, pg, cm, ifl, hf;
   logic [3:0] lag = 4'h1;
   logic [6:0] outs;
   int num_errors = 0;
   int tests_run = 0;
   int unsigned seed_use;

   assign outs = {g, p, d, pg, cm, ifl, hf};

   always #2.5 clk_sys = ~clk_sys;

   hsfs_top #(.REARM_CYC(RRM), .OC_SENSE_CYC(OCS), .POR_CYC(POR)) dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .enable_in(enable_in),
      .regulator_above_rise_in(reg_rise), .regulator_below_drop_in(reg_drop),
      .cap_below_low_in(cap_low), .cap_above_high_in(cap_high),
      .primary_oc_in(oc), .output_feedback_open_in(ofb),
      .return_feedback_open_in(rfb), .undervoltage_low_in(uv),
      .overvoltage_high_in(ov), .output_good_in(out_good),
      .gate_source_good_in(gs_good), .gate_enable_out(g),
      .fault_pulldown_out(p), .discharge_out(d), .power_good_out(pg),
      .current_monitor_out(cm), .current_fault_out(ifl),
      .hard_fault_latched_out(hf));

   hsfs_fet_model fet (.clk_sys(clk_sys), .rst_b(rst_b), .gate_enable_out(g),
      .lag(lag), .output_good_in(out_good), .gate_source_good_in(gs_good));

   // Pull-down follows faults only; an enable-off state masks it.
   function automatic logic [6:0] expect_vec(input logic on, input logic flt,
                                             input logic hfl);
      return {on, flt, ~on, on, on, 1'b0, hfl};
   endfunction : expect_vec

   task automatic hold(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : hold

   task automatic check(input logic [6:0] exp, input logic [6:0] mask,
                        input int wait_max);
      int n;
      n = 0;
      while (((outs & mask) !== exp) && (n < wait_max)) begin
         hold(1);
         n++;
      end
      tests_run++;
      if ((outs & mask) !== exp) begin
         num_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, outs & mask, exp);
      end
   endtask : check

   task automatic turn_on(input logic hfl);
      lag = 4'($urandom_range(1, 8));
      enable_in = 1'b0;
      hold(4);
      enable_in = 1'b1;
      check(expect_vec(1'b1, 1'b0, hfl), M_NIF, 40);
   endtask : turn_on

   task automatic power_up();
      reg_drop = 1'b0;
      reg_rise = 1'b1;
      hold(POR + 12);
   endtask : power_up

   task automatic set_fault(input int i, input logic v);
      case (i)
         0: uv = v;
         1: ov = v;
         2: ofb = v;
         default: rfb = v;
      endcase
   endtask : set_fault

   task automatic conclude();
      if ((num_errors == 0) && (tests_run > 0)) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude

   initial begin
      seed_use = $urandom(32'h355a_579e);
      hold(20);
      check(7'h00, M_ALL, 0);
      rst_b = 1'b1;
      hold(4);
      // Enable raised while the power-on timer still runs must be ignored.
      reg_drop = 1'b0;
      reg_rise = 1'b1;
      enable_in = 1'b1;
      hold(8);
      check(7'h00, 7'h40, 0);
      hold(POR + 8);
      check(7'h00, 7'h40, 0);
      turn_on(1'b0);
      enable_in = 1'b0;
      check(expect_vec(1'b0, 1'b0, 1'b0), M_OFF, 12);
      turn_on(1'b0);
      for (int i = 0; i < 4; i++) begin
         set_fault(i, 1'b1);
         check(expect_vec(1'b0, 1'b1, 1'b0), M_NIF, 12);
         hold($urandom_range(1, 20));
         set_fault(i, 1'b0);
         if (i >= 2) begin
            hold(12);
            check(expect_vec(1'b0, 1'b0, 1'b0), M_OFF, 0);
            turn_on(1'b0);
         end else begin
            check(expect_vec(1'b1, 1'b0, 1'b0), M_NIF, 30);
         end
      end
      // Short dip of the capacitor inside an overcurrent, recharged in time.
      oc = 1'b1;
      cap_high = 1'b0;
      cap_low = 1'b1;
      hold(OCS / 2);
      cap_low = 1'b0;
      hold(4);
      oc = 1'b0;
      hold(RRM / 2);
      cap_high = 1'b1;
      hold(RRM + 12);
      check(expect_vec(1'b1, 1'b0, 1'b0), M_ALL, 0);
      // Capacitor shorted during an overcurrent and never recovering.
      oc = 1'b1;
      cap_high = 1'b0;
      cap_low = 1'b1;
      check(7'h32, M_ALL, OCS + 12);
      oc = 1'b0;
      check(M_HF, M_HF, RRM + 12);
      enable_in = 1'b0;
      hold(10);
      check(7'h11, 7'h53, 0);
      reg_drop = 1'b1;
      reg_rise = 1'b0;
      check(7'h00, 7'h03, 10);
      cap_low = 1'b0;
      cap_high = 1'b1;
      power_up();
      turn_on(1'b0);
      hold(RRM + 12);
      cap_high = 1'b0;
      cap_low = 1'b1;
      check(expect_vec(1'b1, 1'b0, 1'b1), M_ALL, 12);
      cap_low = 1'b0;
      cap_high = 1'b1;
      hold(12);
      check(expect_vec(1'b1, 1'b0, 1'b1), M_ALL, 0);
      reg_drop = 1'b1;
      reg_rise = 1'b0;
      check(7'h00, M_HF, 10);
      conclude();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      conclude();
   end
endmodule : tb_hsfs_top
`default_nettype wire
